// file: dma_defs.svh
// Field positions, address step codes, reset values and sizes of the two-channel DMA controller.
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// ============================================================
// Channel mode register 1 fields
`define M1_SRC_LSB 0
`define M1_DST_LSB 2
`define M1_TMS     4
`define M1_LOW     5
`define M1_DAUE    6
`define M1_CEN     7

// ============================================================
// Channel mode register 2 fields
`define M2_HR_LSB  0
`define M2_SWT     4
`define M2_RLD     5

// ============================================================
// Address step codes
`define STEP_HOLD  2'h0
`define STEP_INC   2'h1
`define STEP_DEC   2'h2

// ============================================================
// Reset values and sizes
`define M1_RST     8'h00
`define HR_RST     4'h0
`define WORD_RST   16'h0000
`define BYTE_RST   8'h00
`define FIFO_DEPTH 16

`endif

// file: dma_pkg.sv
// Types shared by the two-channel DMA controller.
package dma_pkg;

    // ============================================================
    // Engine states
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_READ = 2'b01,
        S_PUSH = 2'b10
    } eng_state_t;

    // ============================================================
    // Register selects shared by both channels
    typedef enum logic [2:0] {
        SEL_MODE1  = 3'b000,
        SEL_MODE2  = 3'b001,
        SEL_SRC_LO = 3'b010,
        SEL_SRC_HI = 3'b011,
        SEL_DST_LO = 3'b100,
        SEL_DST_HI = 3'b101,
        SEL_CNT_LO = 3'b110,
        SEL_CNT_HI = 3'b111
    } reg_sel_t;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        reg_sel_t   sel;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
    } wr_beat_t;

endpackage

// file: dual_channel_dma_controller.sv
// Two-channel byte DMA controller with its write-side FIFO.
`timescale 1ns/10ps
`include "dma_defs.svh"

// ============================================================
// Synchronous FIFO
module dma_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire              i_clk_sys,
    input  wire              i_arst_n,
    // Fill side
    input  wire              i_in_valid,
    output logic             o_in_ready,
    input  wire [WIDTH-1:0]  i_in_data,
    // Drain side
    output logic             o_out_valid,
    input  wire              i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              push = i_in_valid & o_in_ready;
    wire              pop  = o_out_valid & i_out_ready;
    assign o_in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
    assign o_out_valid = wp_q != rp_q;
    assign o_out_data  = mem[rp_q[AW-1:0]];
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= i_in_data;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule // dma_fifo

// ============================================================
// Controller top
module dual_channel_dma_controller
    import dma_pkg::*;
#(
    parameter int NREQ = 16
) (
    // Clock and reset
    input  wire              i_clk_sys,
    input  wire              i_arst_n,
    // Register access
    input  reg_req_t         i_reg,
    input  wire              i_channel_index,
    input  wire              i_reload_disable,
    output logic [7:0]       o_rdata,
    // Requests and processor state
    input  wire [NREQ-1:0]   i_irq_req,
    input  wire              i_cpu_irq_active,
    // Status
    input  wire [1:0]        i_uflow_clr,
    input  wire              i_dma_irq_clr,
    output logic [1:0]       o_uflow,
    output logic [1:0]       o_suspend_flag,
    output logic             o_dma_irq,
    // Memory read
    output logic             o_mem_rd,
    output logic [15:0]      o_mem_raddr,
    input  wire              i_mem_rvalid,
    input  wire [7:0]        i_mem_rdata,
    // Memory write
    output logic             o_mem_wr,
    output logic [15:0]      o_mem_waddr,
    output logic [7:0]       o_mem_wdata,
    input  wire              i_mem_wready
);
    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
        case (m)
            `STEP_INC: step = a + 16'h0001;
            `STEP_DEC: step = a - 16'h0001;
            default:   step = a;
        endcase
    endfunction
    logic [7:0]      m1_q  [2];
    logic [3:0]      hr_q  [2];
    logic [15:0]     src_q [2];
    logic [15:0]     dst_q [2];
    logic [15:0]     cnt_q [2];
    logic [15:0]     src_rl_q [2];
    logic [15:0]     dst_rl_q [2];
    logic [15:0]     cnt_rl_q [2];
    logic [1:0]      pend_q;
    logic [NREQ-1:0] req_prev_q;
    logic            cpu_prev_q;
    logic [7:0]      wtmp_q;
    logic [7:0]      rtmp_q;
    logic [7:0]      byte_q;
    eng_state_t      st_q;
    logic            ch_q;
    wr_beat_t        beat_in;
    wr_beat_t        beat_out;
    logic            f_in_ready;
    logic            f_out_valid;

    // ============================================================
    // Decoding
    wire        c        = i_channel_index;
    wire        wr_m1    = i_reg.wr && i_reg.sel == SEL_MODE1;
    wire        wr_m2    = i_reg.wr && i_reg.sel == SEL_MODE2;
    wire        wr_hi    = i_reg.wr && i_reg.sel[0] && i_reg.sel != SEL_MODE2;
    wire [15:0] wword    = {i_reg.wdata, wtmp_q};
    wire        wr_latch = wr_hi;
    wire        wr_work  = wr_hi && !m1_q[c][`M1_LOW];
    wire [15:0] rword    = (i_reg.sel[2:1] == 2'b01) ? src_q[c] :
                           (i_reg.sel[2:1] == 2'b10) ? dst_q[c] : cnt_q[c];
    wire        cpu_rise = i_cpu_irq_active & ~cpu_prev_q;
    wire        cpu_fall = ~i_cpu_irq_active & cpu_prev_q;
    wire        pushing  = st_q == S_PUSH && f_in_ready;
    wire        uf_now   = cnt_q[ch_q] == 16'h0000;
    wire        f_out_rd = ~o_mem_wr | i_mem_wready;
    wire [1:0]  hw_edge;
    wire [1:0]  sw_trig;
    wire [1:0]  en;
    wire [1:0]  elig;
    wire [1:0]  done;
    wire [1:0]  resume;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            assign en[g]      = m1_q[g][`M1_CEN];
            assign hw_edge[g] = i_irq_req[hr_q[g]] & ~req_prev_q[hr_q[g]];
            assign sw_trig[g] = wr_m2 && c == g && i_reg.wdata[`M2_SWT];
            assign elig[g]    = pend_q[g] & en[g] & ~o_suspend_flag[g];
            assign done[g]    = pushing && ch_q == g
                                && (!m1_q[g][`M1_TMS] || uf_now);
            assign resume[g]  = cpu_fall | (wr_m1 && c == g && i_reg.wdata[`M1_CEN]);
        end
    endgenerate
    assign beat_in = '{addr: dst_q[ch_q], data: byte_q};
    dma_fifo #(
        .WIDTH ($bits(wr_beat_t)),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (st_q == S_PUSH),
        .o_in_ready  (f_in_ready),
        .i_in_data   (beat_in),
        .o_out_valid (f_out_valid),
        .i_out_ready (f_out_rd),
        .o_out_data  (beat_out)
    );

    // ============================================================
    // Engine
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q        <= S_IDLE;
            ch_q        <= 1'b0;
            byte_q      <= `BYTE_RST;
            o_mem_rd    <= 1'b0;
            o_mem_raddr <= `WORD_RST;
        end else begin
            o_mem_rd <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (elig != 2'b00) begin
                        ch_q        <= ~elig[0];
                        o_mem_rd    <= 1'b1;
                        o_mem_raddr <= elig[0] ? src_q[0] : src_q[1];
                        st_q        <= S_READ;
                    end
                end
                S_READ: begin
                    if (i_mem_rvalid) begin
                        byte_q <= i_mem_rdata;
                        st_q   <= S_PUSH;
                    end
                end
                S_PUSH: begin
                    if (f_in_ready) begin
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ============================================================
    // Write side
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_mem_wr    <= 1'b0;
            o_mem_waddr <= `WORD_RST;
            o_mem_wdata <= `BYTE_RST;
        end else if (f_out_rd) begin
            o_mem_wr    <= f_out_valid;
            o_mem_waddr <= beat_out.addr;
            o_mem_wdata <= beat_out.data;
        end
    end

    // ============================================================
    // Register access, requests and status
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wtmp_q         <= `BYTE_RST;
            rtmp_q         <= `BYTE_RST;
            o_rdata        <= `BYTE_RST;
            pend_q         <= 2'h0;
            req_prev_q     <= '0;
            cpu_prev_q     <= 1'b0;
            o_uflow        <= 2'h0;
            o_suspend_flag <= 2'h0;
            o_dma_irq      <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                m1_q[i]     <= `M1_RST;
                hr_q[i]     <= `HR_RST;
                src_q[i]    <= `WORD_RST;
                dst_q[i]    <= `WORD_RST;
                cnt_q[i]    <= `WORD_RST;
                src_rl_q[i] <= `WORD_RST;
                dst_rl_q[i] <= `WORD_RST;
                cnt_rl_q[i] <= `WORD_RST;
            end
        end else begin
            req_prev_q <= i_irq_req;
            cpu_prev_q <= i_cpu_irq_active;
            if (i_reg.wr && !i_reg.sel[0]) begin
                wtmp_q <= i_reg.wdata;
            end
            if (i_reg.rd) begin
                case (i_reg.sel)
                    SEL_MODE1: o_rdata <= m1_q[c];
                    SEL_MODE2: o_rdata <= {4'h0, hr_q[c]};
                    SEL_SRC_HI, SEL_DST_HI, SEL_CNT_HI: begin
                        o_rdata <= rword[15:8];
                        rtmp_q  <= rword[7:0];
                    end
                    default: o_rdata <= rtmp_q;
                endcase
            end
            if (i_dma_irq_clr) begin
                o_dma_irq <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                if (i_uflow_clr[i]) begin
                    o_uflow[i] <= 1'b0;
                end
                if (resume[i]) begin
                    o_suspend_flag[i] <= 1'b0;
                end
                if (cpu_rise && pend_q[i] && en[i]) begin
                    o_suspend_flag[i] <= 1'b1;
                end
                if (done[i] || !en[i]) begin
                    pend_q[i] <= 1'b0;
                end
                if (en[i] && (hw_edge[i] || sw_trig[i])) begin
                    pend_q[i] <= 1'b1;
                end
                if (wr_m1 && c == i) begin
                    m1_q[i] <= i_reg.wdata;
                end
                if (wr_m2 && c == i) begin
                    hr_q[i] <= i_reg.wdata[3:0];
                end
                if (pushing && ch_q == i) begin
                    if (uf_now) begin
                        cnt_q[i]   <= cnt_rl_q[i];
                        src_q[i]   <= i_reload_disable ? step(src_q[i], m1_q[i][1:0])
                                                       : src_rl_q[i];
                        dst_q[i]   <= i_reload_disable ? step(dst_q[i], m1_q[i][3:2])
                                                       : dst_rl_q[i];
                        o_uflow[i] <= 1'b1;
                        o_dma_irq  <= 1'b1;
                        if (m1_q[i][`M1_DAUE]) begin
                            m1_q[i][`M1_CEN] <= 1'b0;
                        end
                    end else begin
                        cnt_q[i] <= cnt_q[i] - 16'h0001;
                        src_q[i] <= step(src_q[i], m1_q[i][`M1_SRC_LSB +: 2]);
                        dst_q[i] <= step(dst_q[i], m1_q[i][`M1_DST_LSB +: 2]);
                    end
                end
                if (wr_latch && c == i) begin
                    case (i_reg.sel)
                        SEL_SRC_HI: src_rl_q[i] <= wword;
                        SEL_DST_HI: dst_rl_q[i] <= wword;
                        default:    cnt_rl_q[i] <= wword;
                    endcase
                end
                if (wr_work && c == i) begin
                    case (i_reg.sel)
                        SEL_SRC_HI: src_q[i] <= wword;
                        SEL_DST_HI: dst_q[i] <= wword;
                        default:    cnt_q[i] <= wword;
                    endcase
                end
                if (wr_m2 && c == i && i_reg.wdata[`M2_RLD]) begin
                    src_q[i] <= src_rl_q[i];
                    dst_q[i] <= dst_rl_q[i];
                    cnt_q[i] <= cnt_rl_q[i];
                end
            end
        end
    end
endmodule // dual_channel_dma_controller

// file: dma_mem_model.sv
// Byte memory model that answers the controller's read and write handshakes.
`timescale 1ns/10ps

// ============================================================
// Memory model
module dma_mem_model (
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_arst_n,
    // Read side
    input  wire        i_mem_rd,
    input  wire [15:0] i_mem_raddr,
    output logic       o_mem_rvalid,
    output logic [7:0] o_mem_rdata,
    // Write side and pacing
    output logic       o_mem_wready,
    input  wire [3:0]  i_rd_lat,
    input  wire        i_wr_stall
);
    logic        busy_q;
    logic [3:0]  wait_q;
    logic [15:0] addr_q;

    assign o_mem_wready = !i_wr_stall;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_q       <= 1'b0;
            wait_q       <= 4'h0;
            addr_q       <= 16'h0000;
            o_mem_rvalid <= 1'b0;
            o_mem_rdata  <= 8'h00;
        end else begin
            o_mem_rvalid <= 1'b0;
            o_mem_rdata  <= ~o_mem_rdata;
            if (i_mem_rd) begin
                busy_q <= 1'b1;
                wait_q <= i_rd_lat;
                addr_q <= i_mem_raddr;
            end else if (busy_q && wait_q == 4'h0) begin
                busy_q       <= 1'b0;
                o_mem_rvalid <= 1'b1;
                o_mem_rdata  <= addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a;
            end else if (busy_q) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule // dma_mem_model

// file: dual_channel_dma_controller_assertions.sv
// Port checks of the two-channel DMA controller.
`timescale 1ns/10ps

// ============================================================
// Checker
module dma_ctrl_checker import dma_pkg::*; #(
    parameter int NREQ = 16
) (
    // Clock, reset and registers
    input wire            i_clk_sys,
    input wire            i_arst_n,
    input reg_req_t       i_reg,
    input wire            i_channel_index,
    input wire            i_reload_disable,
    input wire [7:0]      o_rdata,
    // Requests and status
    input wire [NREQ-1:0] i_irq_req,
    input wire            i_cpu_irq_active,
    input wire [1:0]      i_uflow_clr,
    input wire            i_dma_irq_clr,
    input wire [1:0]      o_uflow,
    input wire [1:0]      o_suspend_flag,
    input wire            o_dma_irq,
    // Memory
    input wire            o_mem_rd,
    input wire [15:0]     o_mem_raddr,
    input wire            i_mem_rvalid,
    input wire [7:0]      i_mem_rdata,
    input wire            o_mem_wr,
    input wire [15:0]     o_mem_waddr,
    input wire [7:0]      o_mem_wdata,
    input wire            i_mem_wready
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence s_gap;
        !o_mem_rd [*2];
    endsequence

    sequence s_quiet;
        !o_mem_rd && !o_mem_wr && o_uflow == 2'b00 && !o_dma_irq;
    endsequence

    a_reset_quiet: assert property ($rose(i_arst_n) |-> s_quiet ##1 !o_mem_rd)
        else $error("activity right after reset");
    a_byte_spacing: assert property (o_mem_rd |=> s_gap)
        else $error("reads closer than three cycles");
    a_wr_hold: assert property (o_mem_wr && !i_mem_wready |=> o_mem_wr
        && $stable(o_mem_waddr) && $stable(o_mem_wdata))
        else $error("write dropped or changed before acceptance");
    a_irq_with_uflow: assert property ($rose(o_uflow[0]) || $rose(o_uflow[1]) |-> o_dma_irq)
        else $error("underflow without dma interrupt");
    a_irq_sticky: assert property (o_dma_irq && !i_dma_irq_clr |=> o_dma_irq)
        else $error("dma interrupt lost");
    a_uflow_sticky: assert property (o_uflow[0] && !i_uflow_clr[0] |=> o_uflow[0])
        else $error("underflow flag lost");
    a_susp_cause: assert property ($rose(o_suspend_flag[0]) || $rose(o_suspend_flag[1])
        |-> $past(i_cpu_irq_active))
        else $error("suspend without interrupt");
    a_susp_clear: assert property ($fell(i_cpu_irq_active) |-> ##[1:2] o_suspend_flag == 2'b00)
        else $error("suspend flag kept after interrupt end");
    a_rdata_hold: assert property (!$past(i_reg.rd) |-> $stable(o_rdata))
        else $error("read data changed without read");
endmodule // dma_ctrl_checker

bind dual_channel_dma_controller dma_ctrl_checker #(.NREQ(NREQ)) u_chk (
    .i_clk_sys, .i_arst_n, .i_reg, .i_channel_index, .i_reload_disable, .o_rdata,
    .i_irq_req, .i_cpu_irq_active, .i_uflow_clr, .i_dma_irq_clr, .o_uflow,
    .o_suspend_flag, .o_dma_irq, .o_mem_rd, .o_mem_raddr, .i_mem_rvalid, .i_mem_rdata,
    .o_mem_wr, .o_mem_waddr, .o_mem_wdata, .i_mem_wready);

// file: tb.sv
// Self-checking testbench of the two-channel DMA controller.
`timescale 1ns/10ps

// ============================================================
// Testbench
module tb import dma_pkg::*; ;
    logic        i_clk_sys = 1'b0, i_arst_n = 1'b0, i_channel_index = 1'b0;
    logic        i_reload_disable = 1'b0, i_cpu_irq_active = 1'b0, i_dma_irq_clr = 1'b0;
    reg_req_t    i_reg = '0;
    logic [15:0] i_irq_req = 16'h0000, o_mem_raddr, o_mem_waddr;
    logic [1:0]  i_uflow_clr = 2'b00, o_uflow, o_suspend_flag;
    logic [7:0]  o_rdata, i_mem_rdata, o_mem_wdata;
    logic        o_dma_irq, o_mem_rd, i_mem_rvalid, o_mem_wr, i_mem_wready, wr_stall = 1'b0;
    logic [3:0]  rd_lat = 4'h0;
    int          miscompares = 0, checks = 0, cycles = 0, rd_cnt = 0;
    wr_beat_t    beats[$];

    dual_channel_dma_controller #(.NREQ(16)) u_dut (.i_clk_sys, .i_arst_n, .i_reg,
        .i_channel_index, .i_reload_disable, .o_rdata, .i_irq_req, .i_cpu_irq_active,
        .i_uflow_clr, .i_dma_irq_clr, .o_uflow, .o_suspend_flag, .o_dma_irq, .o_mem_rd,
        .o_mem_raddr, .i_mem_rvalid, .i_mem_rdata, .o_mem_wr, .o_mem_waddr, .o_mem_wdata,
        .i_mem_wready);
    dma_mem_model u_mem (.i_clk_sys, .i_arst_n, .i_mem_rd(o_mem_rd), .i_mem_raddr(o_mem_raddr),
        .o_mem_rvalid(i_mem_rvalid), .o_mem_rdata(i_mem_rdata), .o_mem_wready(i_mem_wready),
        .i_rd_lat(rd_lat), .i_wr_stall(wr_stall));

    always #50 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys) begin
        cycles++;
        if (o_mem_wr && i_mem_wready) beats.push_back('{o_mem_waddr, o_mem_wdata});
        if (o_mem_rd) rd_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // ============================================================
    // Shared tasks
    function automatic logic [7:0] mbyte(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic reg_op(logic ch, logic wr, reg_sel_t sel, logic [7:0] d);
        i_channel_index = ch;
        i_reg = '{wr, !wr, sel, d};
        cyc(1);
        i_reg = '0;
        cyc(1);
    endtask

    task automatic wr16(logic ch, reg_sel_t sel, logic [15:0] v);
        reg_op(ch, 1'b1, sel, v[7:0]);
        reg_op(ch, 1'b1, reg_sel_t'(sel + 3'h1), v[15:8]);
    endtask

    task automatic chk_reg(logic ch, reg_sel_t sel, logic [15:0] exp, string name);
        logic [15:0] v;
        reg_op(ch, 1'b0, (sel > SEL_MODE2) ? reg_sel_t'(sel + 3'h1) : sel, 8'h00);
        v = {8'h00, o_rdata};
        if (sel > SEL_MODE2) begin
            reg_op(ch, 1'b0, sel, 8'h00);
            v = {v[7:0], o_rdata};
        end
        check(name, v, exp);
    endtask

    task automatic setup(logic ch, logic [15:0] s, d, c, logic [7:0] m1, m2);
        reg_op(ch, 1'b1, SEL_MODE1, m1 & 8'h5f);
        wr16(ch, SEL_SRC_LO, s);
        wr16(ch, SEL_DST_LO, d);
        wr16(ch, SEL_CNT_LO, c);
        reg_op(ch, 1'b1, SEL_MODE2, m2);
        reg_op(ch, 1'b1, SEL_MODE1, m1);
        beats.delete();
    endtask

    task automatic pulse(logic [15:0] req, logic [1:0] uclr, logic iclr);
        i_irq_req = req;
        i_uflow_clr = uclr;
        i_dma_irq_clr = iclr;
        cyc(1);
        i_irq_req = 16'h0000;
        i_uflow_clr = 2'b00;
        i_dma_irq_clr = 1'b0;
        cyc(1);
    endtask

    task automatic wait_min(int n);
        int k;
        k = 0;
        while (beats.size() < n && k < 3000) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic wait_beats(int n);
        wait_min(n);
        cyc(20);
        check("beat count", 16'(beats.size()), 16'(n));
    endtask

    // ============================================================
    // Scenarios
    task automatic t_regs();
        chk_reg(1'b0, SEL_MODE1, 16'h0000, "mode1 reset");
        wr16(1'b0, SEL_SRC_LO, 16'h1234);
        wr16(1'b1, SEL_SRC_LO, 16'hbeef);
        chk_reg(1'b0, SEL_SRC_LO, 16'h1234, "src ch0");
        chk_reg(1'b1, SEL_SRC_LO, 16'hbeef, "src ch1");
        reg_op(1'b0, 1'b1, SEL_MODE1, 8'h20);
        wr16(1'b0, SEL_SRC_LO, 16'h5678);
        chk_reg(1'b0, SEL_SRC_LO, 16'h1234, "latch only");
        reg_op(1'b0, 1'b1, SEL_MODE2, 8'h2a);
        chk_reg(1'b0, SEL_SRC_LO, 16'h5678, "force reload");
        chk_reg(1'b0, SEL_MODE2, 16'h000a, "mode2 strobes");
        $display("test regs done");
    endtask

    task automatic t_steal();
        setup(1'b0, 16'h1000, 16'h2005, 16'h0002, 8'h89, 8'h05);
        reg_op(1'b0, 1'b1, SEL_MODE2, 8'h15);
        wait_beats(1);
        check("addr", beats[0].addr, 16'h2005);
        check("data", 16'(beats[0].data), 16'(mbyte(16'h1000)));
        chk_reg(1'b0, SEL_SRC_LO, 16'h1001, "src inc");
        chk_reg(1'b0, SEL_DST_LO, 16'h2004, "dst dec");
        chk_reg(1'b0, SEL_CNT_LO, 16'h0001, "count dec");
        pulse(16'h0020, 2'b00, 1'b0);
        wait_beats(2);
        check("hw data", 16'(beats[1].data), 16'(mbyte(16'h1001)));
        check("no uflow", 16'(o_uflow), 16'h0000);
        pulse(16'h0020, 2'b00, 1'b0);
        wait_beats(3);
        check("uflow", 16'({o_dma_irq, o_uflow}), 16'h0005);
        chk_reg(1'b0, SEL_SRC_LO, 16'h1000, "src reload");
        chk_reg(1'b0, SEL_CNT_LO, 16'h0002, "count reload");
        pulse(16'h0000, 2'b11, 1'b1);
        check("flags clear", 16'({o_dma_irq, o_uflow}), 16'h0000);
        $display("test cycle steal done");
    endtask

    task automatic t_burst();
        i_reload_disable = 1'b1;
        wr_stall = 1'b1;
        setup(1'b1, 16'h4000, 16'h5000, 16'h0013, 8'hd4, 8'h00);
        rd_cnt = 0;
        reg_op(1'b1, 1'b1, SEL_MODE2, 8'h10);
        cyc(300);
        check("fifo full", 16'(rd_cnt inside {[16:18]}), 16'h0001);
        wr_stall = 1'b0;
        wait_beats(20);
        check("last addr", beats[19].addr, 16'h5013);
        check("last data", 16'(beats[19].data), 16'(mbyte(16'h4000)));
        check("uflow ch1", 16'(o_uflow), 16'h0002);
        chk_reg(1'b1, SEL_MODE1, 16'h0054, "auto disable");
        chk_reg(1'b1, SEL_DST_LO, 16'h5014, "no addr reload");
        chk_reg(1'b1, SEL_CNT_LO, 16'h0013, "count reload");
        i_reload_disable = 1'b0;
        pulse(16'h0000, 2'b11, 1'b1);
        $display("test burst done");
    endtask

    task automatic t_prio();
        int pos;
        pos = 0;
        rd_lat = 4'h2;
        setup(1'b0, 16'h0100, 16'h3000, 16'h0005, 8'h85, 8'h03);
        setup(1'b1, 16'h0200, 16'h6000, 16'h0009, 8'h95, 8'h03);
        pulse(16'h0008, 2'b00, 1'b0);
        wait_min(3);
        reg_op(1'b0, 1'b1, SEL_MODE2, 8'h13);
        wait_beats(12);
        foreach (beats[i]) if (beats[i].addr == 16'h3001) pos = i;
        check("ch0 first", beats[0].addr, 16'h3000);
        check("ch0 cuts in", 16'(pos inside {[3:10]}), 16'h0001);
        check("ch1 resumed", beats[11].addr, 16'h6009);
        $display("test priority done");
    endtask

    task automatic t_susp();
        rd_lat = 4'h4;
        setup(1'b1, 16'h0300, 16'h7000, 16'h0013, 8'h95, 8'h00);
        reg_op(1'b1, 1'b1, SEL_MODE2, 8'h10);
        wait_min(2);
        i_cpu_irq_active = 1'b1;
        cyc(6);
        check("suspend", 16'(o_suspend_flag), 16'h0002);
        rd_cnt = 0;
        cyc(20);
        check("held", 16'(rd_cnt), 16'h0000);
        i_cpu_irq_active = 1'b0;
        cyc(2);
        check("resume", 16'(o_suspend_flag), 16'h0000);
        cyc(10);
        i_cpu_irq_active = 1'b1;
        cyc(6);
        check("suspend again", 16'(o_suspend_flag), 16'h0002);
        reg_op(1'b1, 1'b1, SEL_MODE1, 8'h95);
        check("early resume", 16'(o_suspend_flag), 16'h0000);
        wait_beats(20);
        check("continued", beats[19].addr, 16'h7013);
        i_cpu_irq_active = 1'b0;
        $display("test suspend done");
    endtask

    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        cyc(3);
        i_arst_n = 1'b1;
        cyc(1);
        t_regs();
        t_steal();
        t_burst();
        t_prio();
        t_susp();
        end_sim();
    end
endmodule // tb
